/* File: dv/cfg_port_model.sv */
`timescale 1ns/1ps
module cfg_port_model (
    input wire logic dev_oe,
    input wire logic dev_level,
    output logic cfg_clk,
    output logic reset_pin_level
);
    // ----------------------------------------------------------------
    // open-drain reset pin with pull-up
    // ----------------------------------------------------------------
    logic hold_low = 1'h0;
    assign reset_pin_level = ((dev_oe && !dev_level) || hold_low) ? 1'h0 : 1'h1;

    // ----------------------------------------------------------------
    // configuration clock, 80 ns, still between bursts
    // ----------------------------------------------------------------
    initial cfg_clk = 1'h0;
    // no jtag pin is pulled low and no test clock toggles here

    task automatic pulse(input int n);
        repeat (n) begin
            #7;
            cfg_clk = 1'h1;
            #40;
            cfg_clk = 1'h0;
            #33;
        end
    endtask
endmodule

/* File: dv/tb_config_prom_address_sequencer.sv */
`timescale 1ns/1ps
module tb_config_prom_address_sequencer;
    import cfg_prom_pkg::*;
    localparam int AW = 6;
    localparam int DW = 8;
    localparam int REL = 20;
    localparam int PD = 30;

    logic sys_clk = 1'h0;
    logic srst = 1'h1;
    logic ce_n = 1'h0;
    logic cf_n = 1'h1;
    logic busy = 1'h0;
    logic sup_ok = 1'h0;
    logic sup_low = 1'h0;
    logic rev_en = 1'h0;
    logic [1:0] rev_sel = 2'h0;
    logic par = 1'h0;
    logic dec = 1'h0;
    logic wr_en = 1'h0;
    logic [AW-1:0] wr_addr = 6'h00;
    logic [DW-1:0] wr_data = 8'h00;
    logic cfg_clk;
    logic rst_pin;
    pin_in_t pins;
    logic [DW-1:0] data_out;
    logic data_oe;
    logic fwd_oe;
    logic fwd_clk;
    logic cas_n;
    logic rst_out;
    logic rst_oe;
    logic standby;
    logic reduced;
    int n_errors = 0;
    int samples_checked = 0;
    int n_fwd = 0;

    always #5 sys_clk = ~sys_clk;

    // counts rising edges of the forwarded clock
    always @(posedge fwd_clk) n_fwd++;

    assign pins = {rst_pin, ce_n, cf_n, busy, cfg_clk, sup_ok, sup_low, rev_en, rev_sel, par, dec};

    config_prom_address_sequencer #(
        .ADDR_W(AW),
        .DATA_W(DW),
        .FIFO_DEPTH(16),
        .RELEASE_CYC(REL),
        .RELEASE_MAX_CYC(40),
        .POWER_DOWN_CYC(PD)
    ) uut (
        .sys_clk(sys_clk),
        .srst(srst),
        .pins(pins),
        .prog_wr_en(wr_en),
        .prog_addr(wr_addr),
        .prog_data(wr_data),
        .data_out(data_out),
        .data_oe(data_oe),
        .forwarded_clock(fwd_clk),
        .forwarded_clock_oe(fwd_oe),
        .cascade_enable_out_n(cas_n),
        .oe_reset_n_out(rst_out),
        .oe_reset_n_oe(rst_oe),
        .standby(standby),
        .reduced_current(reduced)
    );

    cfg_port_model fpga (
        .dev_oe(rst_oe),
        .dev_level(rst_out),
        .cfg_clk(cfg_clk),
        .reset_pin_level(rst_pin)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [DW-1:0] word(input logic [AW-1:0] a);
        return {2'h0, a} ^ 8'hA5;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic set_straps(input logic r_en, input logic [1:0] sel, input logic p,
                              input logic d, input logic b);
        rev_en = r_en;
        rev_sel = sel;
        par = p;
        dec = d;
        busy = b;
        tick(4);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic chk_word(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_program;
        for (int a = 0; a < 64; a++) begin
            wr_en = 1'h1;
            wr_addr = a[AW-1:0];
            wr_data = word(a[AW-1:0]);
            tick(1);
        end
        wr_en = 1'h0;
    endtask

    task automatic t_power_up;
        int i;
        tick(10);
        chk_bit(rst_oe, 1'h1, "reset pin not held in power-up");
        chk_bit(rst_out, 1'h0, "reset pin driven high");
        sup_ok = 1'h1;
        i = 0;
        while (rst_oe !== 1'h0 && i < 100) begin
            tick(1);
            i++;
        end
        chk_bit(i >= REL && i <= REL + 8, 1'h1, "release delay");
        tick(1);
        chk_bit(rst_pin, 1'h1, "reset pin not released");
    endtask

    task automatic cf_pulse;
        cf_n = 1'h0;
        tick(6);
        chk_bit(data_oe, 1'h1, "data floats in address reset");
        chk_bit(cas_n, 1'h1, "cascade in address reset");
        cf_n = 1'h1;
        tick(30);
    endtask

    task automatic run(input logic [AW-1:0] start, input int n, input logic exp_cas);
        int f0;
        cf_pulse();
        f0 = n_fwd;
        chk_word(data_out, word(start), "start word");
        for (int i = 1; i < n; i++) begin
            fpga.pulse(1);
            tick(3);
            chk_word(data_out, word(AW'(start + i)), "stepped word");
            chk_bit(fwd_oe, 1'h1, "clock not driven");
        end
        fpga.pulse(1);
        tick(3);
        chk_bit(data_oe, 1'h0, "data driven at end");
        chk_bit(fwd_oe, 1'h0, "clock driven at end");
        chk_bit(reduced, 1'h1, "current not reduced");
        chk_bit(cas_n, exp_cas, "cascade at end");
        fpga.pulse(2);
        tick(3);
        chk_bit(data_oe, 1'h0, "end not held");
        chk_bit(cas_n, exp_cas, "cascade not held");
        chk_bit(n_fwd - f0 == n + 2, 1'h1, "forwarded clock edges");
    endtask

    task automatic t_standby;
        ce_n = 1'h1;
        tick(6);
        chk_bit(standby, 1'h1, "no standby");
        chk_bit(data_oe, 1'h0, "data driven in standby");
        chk_bit(fwd_oe, 1'h0, "clock driven in standby");
        chk_bit(cas_n, 1'h1, "cascade low in standby");
        fpga.hold_low = 1'h1;
        tick(6);
        chk_bit(standby, 1'h1, "standby lost with reset pin low");
        chk_bit(data_oe, 1'h0, "data driven with reset pin low");
        fpga.hold_low = 1'h0;
        ce_n = 1'h0;
        tick(30);
        chk_word(data_out, word(6'h00), "address not reset by standby");
    endtask

    task automatic t_busy;
        set_straps(1'h0, 2'h0, 1'h1, 1'h0, 1'h1);
        fpga.pulse(3);
        tick(3);
        chk_word(data_out, word(6'h00), "busy did not freeze");
        chk_bit(data_oe, 1'h1, "data floats while busy");
        set_straps(1'h0, 2'h0, 1'h1, 1'h0, 1'h0);
        fpga.pulse(1);
        tick(3);
        chk_word(data_out, word(6'h01), "no step after busy");
        set_straps(1'h0, 2'h0, 1'h1, 1'h1, 1'h1);
        fpga.pulse(1);
        tick(3);
        chk_word(data_out, word(6'h02), "busy honoured with decompression");
        set_straps(1'h0, 2'h0, 1'h0, 1'h0, 1'h1);
        fpga.pulse(1);
        tick(3);
        chk_word(data_out, word(6'h03), "busy honoured in serial mode");
        set_straps(1'h0, 2'h0, 1'h0, 1'h0, 1'h0);
    endtask

    task automatic t_oe_low;
        fpga.hold_low = 1'h1;
        tick(6);
        chk_bit(data_oe, 1'h0, "data driven with reset low");
        chk_bit(fwd_oe, 1'h0, "clock driven with reset low");
        chk_bit(cas_n, 1'h1, "cascade with reset low");
        chk_bit(standby, 1'h0, "standby with reset low");
        fpga.pulse(2);
        tick(1);
        fpga.hold_low = 1'h0;
        tick(30);
        chk_word(data_out, word(6'h00), "address not reset by reset pin");
    endtask

    task automatic t_power_down;
        int i;
        sup_low = 1'h1;
        tick(PD - 2);
        chk_bit(rst_oe, 1'h0, "early power-down reset");
        i = 0;
        while (rst_oe !== 1'h1 && i < 20) begin
            tick(1);
            i++;
        end
        chk_bit(rst_oe, 1'h1, "no power-down reset");
        tick(3);
        chk_bit(data_oe, 1'h0, "data driven in power-down");
        sup_low = 1'h0;
        i = 0;
        while (rst_oe !== 1'h0 && i < 100) begin
            tick(1);
            i++;
        end
        chk_bit(i >= REL && i <= REL + 8, 1'h1, "release delay after power-down");
        tick(30);
        chk_word(data_out, word(6'h00), "address after full reset");
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        tick(6);
        srst = 1'h0;
        t_program();
        t_power_up();
        run(6'h00, 63, 1'h0);
        t_standby();
        t_busy();
        t_oe_low();
        t_power_down();
        set_straps(1'h1, 2'h1, 1'h0, 1'h0, 1'h0);
        run(6'h10, 15, 1'h1);
        set_straps(1'h1, 2'h3, 1'h0, 1'h0, 1'h0);
        run(6'h30, 15, 1'h0);
        end_sim();
    end

    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
endmodule

/* File: hdl/config_prom_address_sequencer.sv */
// Notes on behaviour
// [R01] chip deselected: standby, address reset, cascade output high
// [R02] standby floats every output except cascade, whatever the reset pin does
// [R03] outside party keeps JTAG pins high and its clock still for standby
// [R04] enabled and not busy: address steps per clock, data and clock driven
// [R05] at revision end below terminal: hold address, float, reduced current
// [R06] at terminal count: hold address, float, cascade output low
// [R07] busy freezes address and data; only parallel mode without decompression
// [R08] terminal is the top address; revision end is the selected bank's last
// [R09] revisions enabled: address resets load the selected bank's start
// [R10] revisions disabled: address resets load zero
// [R11] reset pin released between 0.5 ms and 30 ms after supply is good
// [R12] supply under power-down level for 10 ms forces a full reset
// [R13] reset pin low: address reset, cascade high, data and clock float
// [R14] device drives reset pin low during power-up and after power-down reset
// [R15] config pulse low while enabled resets address, outputs stay driven
`timescale 1ns/1ps
module config_prom_address_sequencer
    import cfg_prom_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter int RELEASE_CYC = RELEASE_CYCLES,
    parameter int RELEASE_MAX_CYC = RELEASE_MAX_CYCLES,
    parameter int POWER_DOWN_CYC = POWER_DOWN_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire pin_in_t pins,
    input wire logic prog_wr_en,
    input wire logic [ADDR_W-1:0] prog_addr,
    input wire logic [DATA_W-1:0] prog_data,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    output logic forwarded_clock,
    output logic forwarded_clock_oe,
    output logic cascade_enable_out_n,
    output logic oe_reset_n_out,
    output logic oe_reset_n_oe,
    output logic standby,
    output logic reduced_current
);
    localparam int PIN_W = $bits(pin_in_t);
    localparam logic [ADDR_W-1:0] TERMINAL_COUNT = '1;
    localparam int PD_LAT_MIN = 1;
    localparam int PD_LAT_MAX = 2;

    function automatic logic [ADDR_W-1:0] bank_addr(input logic [BANK_SEL_W-1:0] sel,
                                                    input logic last);
        bank_addr = {sel, {(ADDR_W - BANK_SEL_W){last}}};
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [PIN_W-1:0] meta_r;
    logic [PIN_W-1:0] sync_r;
    pin_in_t ps;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
        end
    end
    assign ps = sync_r;

    // ----------------------------------------------------------------
    // power-on release and power-down detection
    // ----------------------------------------------------------------
    logic [31:0] rel_cnt_r;
    logic [31:0] pd_cnt_r;
    logic released_r;
    logic pd_trip;
    logic supply_good;

    assign supply_good = ps.core_supply_ok && !ps.core_supply_low;
    assign pd_trip = ps.core_supply_low && (pd_cnt_r == 32'(POWER_DOWN_CYC - 1)); // R12

    always_ff @(posedge sys_clk) begin
        if (srst || !ps.core_supply_low || pd_trip) begin
            pd_cnt_r <= '0;
        end else begin
            pd_cnt_r <= pd_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || pd_trip) begin
            rel_cnt_r <= '0;
            released_r <= 1'b0; // R12 R14
        end else if (!released_r) begin
            if (!supply_good) begin
                rel_cnt_r <= '0;
            end else if (rel_cnt_r == 32'(RELEASE_CYC - 1)) begin
                released_r <= 1'b1; // R11
            end else begin
                rel_cnt_r <= rel_cnt_r + 32'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // address control
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic [BANK_SEL_W-1:0] bank_sel_r;
    logic [BANK_SEL_W-1:0] bank_sel_nxt;
    logic [ADDR_W-1:0] start_addr;
    logic [ADDR_W-1:0] rev_last;
    logic [ADDR_W-1:0] rev_last_nxt;
    logic reset_cond;
    logic busy_eff;
    logic at_stop;
    logic pending_r;
    logic present_vld_r;
    logic advance;
    logic load_first;
    logic cfg_d_r;
    logic cfg_edge;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    seq_state_t state_r;
    seq_state_t st_nxt;

    assign reset_cond = !released_r || ps.device_select_n || !ps.oe_reset_n
                        || !ps.config_pulse_n; // R01 R13 R15
    assign busy_eff = ps.busy && ps.parallel_mode && !ps.decompress_enable; // R07
    assign start_addr = ps.revision_enable ? bank_addr(ps.revision_select, 1'b0)
                                           : '0; // R09 R10
    assign rev_last = bank_addr(bank_sel_r, 1'b1); // R08
    assign at_stop = (addr_r == TERMINAL_COUNT)
                     || (ps.revision_enable && addr_r == rev_last); // R05 R06
    assign cfg_edge = ps.cfg_clk && !cfg_d_r;
    assign advance = !reset_cond && pending_r && present_vld_r && fifo_out_valid
                     && !busy_eff && !at_stop; // R04
    assign load_first = !reset_cond && !present_vld_r && fifo_out_valid;
    assign bank_sel_nxt = reset_cond ? ps.revision_select : bank_sel_r;
    assign rev_last_nxt = bank_addr(bank_sel_nxt, 1'b1);

    always_comb begin
        if (reset_cond) begin
            addr_nxt = start_addr;
        end else if (advance) begin
            addr_nxt = addr_r + 1'b1;
        end else begin
            addr_nxt = addr_r;
        end
    end

    always_comb begin
        if (!released_r) begin
            st_nxt = ST_POWER_UP;
        end else if (ps.device_select_n) begin
            st_nxt = ST_STANDBY;
        end else if (!ps.oe_reset_n) begin
            st_nxt = ST_HELD_RESET;
        end else if (!ps.config_pulse_n) begin
            st_nxt = ST_CF_RESET;
        end else if (addr_nxt == TERMINAL_COUNT) begin
            st_nxt = ST_TERMINAL;
        end else if (ps.revision_enable && addr_nxt == rev_last_nxt) begin
            st_nxt = ST_REV_END;
        end else begin
            st_nxt = ST_READ;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            addr_r <= '0;
            bank_sel_r <= '0;
            state_r <= ST_POWER_UP;
            cfg_d_r <= 1'b0;
        end else begin
            addr_r <= addr_nxt; // R04 R09 R10
            bank_sel_r <= bank_sel_nxt;
            state_r <= st_nxt;
            cfg_d_r <= ps.cfg_clk;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || reset_cond) begin
            pending_r <= 1'b0;
        end else if (cfg_edge && !busy_eff) begin
            pending_r <= 1'b1;
        end else if (advance) begin
            pending_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // stored words and prefetch
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] store [2**ADDR_W];
    logic [ADDR_W:0] fetch_addr_r;
    logic [ADDR_W-1:0] fetch_stop;
    logic can_fetch;
    logic rd_vld_r;
    logic [DATA_W-1:0] rd_data_r;

    assign fetch_stop = ps.revision_enable ? rev_last : TERMINAL_COUNT;
    assign can_fetch = fetch_addr_r <= {1'b0, fetch_stop};

    always_ff @(posedge sys_clk) begin
        if (prog_wr_en) begin
            store[prog_addr] <= prog_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || reset_cond) begin
            fetch_addr_r <= {1'b0, start_addr};
            rd_vld_r <= 1'b0;
            rd_data_r <= '0;
        end else if (!rd_vld_r || fifo_in_ready) begin
            rd_vld_r <= can_fetch;
            if (can_fetch) begin
                rd_data_r <= store[fetch_addr_r[ADDR_W-1:0]];
                fetch_addr_r <= fetch_addr_r + 1'b1;
            end
        end
    end

    prefetch_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .flush(reset_cond),
        .in_valid(rd_vld_r),
        .in_ready(fifo_in_ready),
        .in_data(rd_data_r),
        .out_valid(fifo_out_valid),
        .out_ready(advance || load_first),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            data_out <= '0;
            present_vld_r <= 1'b0;
        end else if (reset_cond) begin
            present_vld_r <= 1'b0;
        end else if (advance || load_first) begin
            data_out <= fifo_out_data; // R07
            present_vld_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            data_oe <= 1'b0;
            forwarded_clock <= 1'b0;
            forwarded_clock_oe <= 1'b0;
            cascade_enable_out_n <= 1'b1;
            oe_reset_n_out <= 1'b0;
            oe_reset_n_oe <= 1'b1;
            standby <= 1'b0;
            reduced_current <= 1'b0;
        end else begin
            data_oe <= (st_nxt == ST_READ) || (st_nxt == ST_CF_RESET); // R02 R04 R13 R15
            forwarded_clock <= ps.cfg_clk;
            forwarded_clock_oe <= (st_nxt == ST_READ) || (st_nxt == ST_CF_RESET); // R05
            cascade_enable_out_n <= (st_nxt != ST_TERMINAL); // R01 R06
            oe_reset_n_out <= 1'b0;
            oe_reset_n_oe <= (st_nxt == ST_POWER_UP); // R14
            standby <= (st_nxt == ST_STANDBY); // R01
            reduced_current <= (st_nxt == ST_REV_END) || (st_nxt == ST_TERMINAL); // R05
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [31:0] ok_run_r;

    always_ff @(posedge sys_clk) begin
        if (srst || !supply_good || !oe_reset_n_oe) begin
            ok_run_r <= '0;
        end else begin
            ok_run_r <= ok_run_r + 32'h1;
        end
    end

    property p_standby;
        @(posedge sys_clk) disable iff (srst)
        (ps.device_select_n && released_r && !pd_trip)
            |=> (standby && !data_oe && !forwarded_clock_oe && cascade_enable_out_n);
    endproperty
    a_standby: assert property (p_standby) else $error("standby outputs wrong"); // R01 R02

    property p_zero_reset;
        @(posedge sys_clk) disable iff (srst)
        (reset_cond && !ps.revision_enable) |=> (addr_r == '0);
    endproperty
    a_zero_reset: assert property (p_zero_reset) else $error("address not zero"); // R10

    property p_bank_reset;
        @(posedge sys_clk) disable iff (srst)
        (reset_cond && ps.revision_enable)
            |=> (addr_r == bank_addr($past(ps.revision_select), 1'b0));
    endproperty
    a_bank_reset: assert property (p_bank_reset) else $error("bank start wrong"); // R09

    property p_step;
        @(posedge sys_clk) disable iff (srst)
        (state_r == ST_READ && advance) |=> (addr_r == $past(addr_r) + 1'b1) && (data_oe || at_stop);
    endproperty
    a_step: assert property (p_step) else $error("address did not step"); // R04

    property p_rev_end;
        @(posedge sys_clk) disable iff (srst)
        (state_r == ST_REV_END && !reset_cond) |=> $stable(addr_r) && !data_oe
            && !forwarded_clock_oe && reduced_current && cascade_enable_out_n;
    endproperty
    a_rev_end: assert property (p_rev_end) else $error("revision end wrong"); // R05

    property p_terminal;
        @(posedge sys_clk) disable iff (srst)
        (state_r == ST_TERMINAL) |-> (addr_r == TERMINAL_COUNT) && !cascade_enable_out_n
            && !data_oe && !forwarded_clock_oe;
    endproperty
    a_terminal: assert property (p_terminal) else $error("terminal outputs wrong"); // R06 R08

    property p_busy;
        @(posedge sys_clk) disable iff (srst)
        (busy_eff && !reset_cond && present_vld_r) |=> $stable(addr_r) && $stable(data_out);
    endproperty
    a_busy: assert property (p_busy) else $error("busy did not freeze"); // R07

    property p_release;
        @(posedge sys_clk) disable iff (srst)
        $fell(oe_reset_n_oe) |-> ($past(ok_run_r) >= 32'(RELEASE_CYC - 1))
            && ($past(ok_run_r) <= 32'(RELEASE_MAX_CYC));
    endproperty
    a_release: assert property (p_release) else $error("release delay out of range"); // R11

    property p_power_down;
        @(posedge sys_clk) disable iff (srst)
        pd_trip |-> ##[PD_LAT_MIN:PD_LAT_MAX] oe_reset_n_oe;
    endproperty
    a_power_down: assert property (p_power_down) else $error("no power-down reset"); // R12

    property p_pin_reset;
        @(posedge sys_clk) disable iff (srst)
        (!ps.oe_reset_n && !ps.device_select_n && released_r && !pd_trip)
            |=> cascade_enable_out_n && !data_oe && !forwarded_clock_oe && !pending_r;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset wrong"); // R13

    property p_power_up_drive;
        @(posedge sys_clk) disable iff (srst)
        !released_r |=> oe_reset_n_oe && !oe_reset_n_out;
    endproperty
    a_power_up_drive: assert property (p_power_up_drive) else $error("reset pin not held"); // R14

    property p_cf_reset;
        @(posedge sys_clk) disable iff (srst)
        (!ps.config_pulse_n && ps.oe_reset_n && !ps.device_select_n && released_r
            && !pd_trip) |=> data_oe && forwarded_clock_oe && (addr_r == $past(start_addr));
    endproperty
    a_cf_reset: assert property (p_cf_reset) else $error("config pulse reset wrong"); // R15
endmodule

/* File: hdl/prefetch_fifo.sv */
`timescale 1ns/1ps
module prefetch_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != FULL_CNT);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

/* File: pkg/cfg_prom_pkg.sv */
package cfg_prom_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int RELEASE_MIN_US = 500;
    localparam int RELEASE_MAX_US = 30000;
    localparam int POWER_DOWN_MIN_US = 10000;
    // least times round up; these products are exact at whole MHz
    localparam int RELEASE_CYCLES = RELEASE_MIN_US * CLK_MHZ;
    localparam int RELEASE_MAX_CYCLES = RELEASE_MAX_US * CLK_MHZ;
    localparam int POWER_DOWN_CYCLES = POWER_DOWN_MIN_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W_DEF = 10;
    localparam int DATA_W_DEF = 8;
    localparam int FIFO_DEPTH_DEF = 16;
    localparam int BANK_SEL_W = 2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum {
        ST_POWER_UP,
        ST_STANDBY,
        ST_HELD_RESET,
        ST_CF_RESET,
        ST_READ,
        ST_REV_END,
        ST_TERMINAL
    } seq_state_t;

    typedef struct packed {
        logic oe_reset_n;
        logic device_select_n;
        logic config_pulse_n;
        logic busy;
        logic cfg_clk;
        logic core_supply_ok;
        logic core_supply_low;
        logic revision_enable;
        logic [BANK_SEL_W-1:0] revision_select;
        logic parallel_mode;
        logic decompress_enable;
    } pin_in_t;

endpackage
